// ---- hdl/fawp_pkg.sv ----
// Purpose: Shared types and constants for flash array write protection
// Assumes: Requests come from a command decoder on the same clock
// Notes:   Sector index is address bits 24:16

package fawp_pkg;

   // Array organisation
   localparam int ADDR_W         = 25;
   localparam int SECTOR_COUNT   = 512;
   localparam int SECTOR_W       = 9;
   localparam int SECTOR_LSB     = 16;
   localparam int PAGE_LSB       = 8;
   localparam int PAGE_W         = 17;
   localparam int SUBSECTOR_LSB  = 12;
   localparam int OTP_BYTES      = 64;
   localparam int OTP_ADDR_W     = 6;

   // Block-protect decode
   localparam logic [3:0] BP_NONE      = 4'h0;
   localparam logic [3:0] BP_LAST_SIZE = 4'h9;

   // Reset values
   localparam logic       WLOCK_RESET  = 1'h1;
   localparam logic       LDOWN_RESET  = 1'h0;
   localparam logic [3:0] BP_RESET     = 4'h0;
   localparam logic       TOP_BOTTOM_RESET = 1'h0;

   // Power-up hold-off
   localparam int CLK_HZ         = 10_000_000;
   localparam int PU_TIME_US     = 300;
   localparam int PU_CYCLES      = (PU_TIME_US * (CLK_HZ / 1_000_000));
   localparam int PU_W           = 12;
   localparam logic [PU_W-1:0] PU_LAST = PU_W'(PU_CYCLES - 1);

   typedef enum logic [3:0] {
      CMD_WRITE_ENABLE,
      CMD_WRITE_DISABLE,
      CMD_PAGE_PROGRAM,
      CMD_OTP_PROGRAM,
      CMD_PAGE_ERASE,
      CMD_SUBSECTOR_ERASE,
      CMD_SECTOR_ERASE,
      CMD_BULK_ERASE,
      CMD_WRITE_LOCK,
      CMD_WRITE_STATUS
   } fawp_cmd_t;

   typedef struct packed {
      fawp_cmd_t           kind;         // Command
      logic [ADDR_W-1:0]   addr;         // Byte address
      logic                byte_whole;   // Clock count multiple of 8
      logic                lock_down;    // Lock-down value to write
      logic                write_lock;   // Write-lock value to write
      logic [3:0]          bp;           // Block-protect code to write
      logic                top_bottom_select; // Top/bottom to write
      logic [7:0]          new_data;     // Byte to program
      logic [7:0]          old_data;     // Byte now in the array
   } fawp_req_t;

   typedef struct packed {
      logic                grant;        // Operation may proceed
      logic                refuse;       // Command discarded
      fawp_cmd_t           kind;         // Command answered
      logic [ADDR_W-1:0]   addr;         // Target address, aligned only for erases
      logic [7:0]          data;         // Byte to store after program
   } fawp_ans_t;

endpackage : fawp_pkg

// ---- hdl/fawp_bp_decode.sv ----
// Purpose: Decode block-protect code and top/bottom into a sector verdict
// Assumes: Code and sector are stable in the cycle they are read
// Notes:   Purely combinational

`timescale 1ns/1ns

module fawp_bp_decode (
   input  wire logic [3:0]                    bp,                // Code
   input  wire logic                          top_bottom_select, // Top/bottom
   input  wire logic [fawp_pkg::SECTOR_W-1:0] sector,            // Sector
   output logic                               prot               // Protected
);

   logic [fawp_pkg::SECTOR_W:0] span;

   // Span of 2^(code-1) sectors from the chosen end
   always_comb begin
      span = '0;
      prot = 1'b0;
      if (bp == fawp_pkg::BP_NONE) begin
         prot = 1'b0;
      end else if (bp > fawp_pkg::BP_LAST_SIZE) begin
         prot = 1'b1;
      end else begin
         span = (fawp_pkg::SECTOR_W+1)'(1) << (bp - 4'h1);
         if (top_bottom_select)
            prot = {1'b0, sector} < span;
         else
            prot = {1'b0, sector} >=
                   (fawp_pkg::SECTOR_W+1)'(fawp_pkg::SECTOR_COUNT) - span;
      end
   end

endmodule : fawp_bp_decode

// ---- hdl/fawp_guard.sv ----
// Purpose: Gate program, erase and register writes on all protection
// Assumes: Requests arrive as one-cycle pulses from logic on clk
// Notes:   Array storage is outside; this block only decides and merges

`timescale 1ns/1ns

module fawp_guard (
   input  wire logic                clk,        // 10 MHz clock
   input  wire logic                resetn,     // Async reset, active low
   input  wire logic                req_valid,  // Request pulse
   input  wire fawp_pkg::fawp_req_t req,        // Request contents
   input  wire logic                wp_enable,  // Pin acts as protection
   input  wire logic                write_protect_n, // Protect pin, async
   output fawp_pkg::fawp_ans_t      ans,        // Registered answer
   output logic                     wel,        // Write enable latch
   output logic [3:0]               bp_status,  // Block-protect code
   output logic                     top_bottom_status, // Top/bottom select
   output logic                     ready       // Power-up complete
);

   // Whole state of the guard in one record
   typedef struct packed {
      logic [fawp_pkg::PU_W-1:0]         pu_count;
      logic                              pu_done;
      logic                              wp_meta;
      logic                              wp_sync;
      logic                              wel;
      logic [3:0]                        bp;
      logic                              top_bottom_select;
      // One lock and one lock-down bit per sector
      logic [fawp_pkg::SECTOR_COUNT-1:0] wlock;
      logic [fawp_pkg::SECTOR_COUNT-1:0] ldown;
      fawp_pkg::fawp_ans_t               ans;
   } fawp_state_t;

   // State record and request decode helpers
   fawp_state_t                      cur;
   fawp_state_t                      next_cur;
   logic [fawp_pkg::SECTOR_W-1:0]    sector;
   logic                             bp_prot;
   logic                             modify;
   logic                             ok;
   logic                             any_lock;

   // Contiguous map: 64 KB sector index from the upper address bits
   assign sector = req.addr[fawp_pkg::SECTOR_LSB +:
                            fawp_pkg::SECTOR_W];

   // Block-protect range decode for the targeted sector
   fawp_bp_decode u_bp (
      .bp                (cur.bp),
      .top_bottom_select (cur.top_bottom_select),
      .sector            (sector),
      .prot              (bp_prot)
   );

   // Classify the request and check the common gates
   always_comb begin
      modify   = (req.kind != fawp_pkg::CMD_WRITE_ENABLE) &&
                 (req.kind != fawp_pkg::CMD_WRITE_DISABLE);
      any_lock = |cur.wlock;
      ok       = cur.pu_done
                 && req.byte_whole
                 && cur.wel;
   end

   // Next-state logic
   always_comb begin
      next_cur            = cur;
      next_cur.ans.grant  = 1'b0;
      next_cur.ans.refuse = 1'b0;
      // Pin crosses two flops before anything reads it
      next_cur.wp_meta    = write_protect_n;
      next_cur.wp_sync    = cur.wp_meta;
      // Hold-off count after reset
      if (!cur.pu_done) begin
         if (cur.pu_count == fawp_pkg::PU_LAST)
            next_cur.pu_done = 1'b1;
         else
            next_cur.pu_count = cur.pu_count + 1'b1;
      end
      if (req_valid) begin
         next_cur.ans.kind = req.kind;
         next_cur.ans.addr = req.addr;
         next_cur.ans.data = req.old_data;
         if (req.kind == fawp_pkg::CMD_WRITE_ENABLE) begin
            // Latch can only be set once power-up is over
            next_cur.wel       = cur.pu_done;
            next_cur.ans.grant = cur.pu_done;
            next_cur.ans.refuse = !cur.pu_done;
         end else if (req.kind == fawp_pkg::CMD_WRITE_DISABLE) begin
            // Dropping the latch is harmless, so never refused
            next_cur.wel       = 1'b0;
            next_cur.ans.grant = 1'b1;
         end else begin
            // Latch is spent by any modify attempt
            next_cur.wel        = 1'b0;
            next_cur.ans.refuse = 1'b1;
            unique case (req.kind)
               fawp_pkg::CMD_PAGE_PROGRAM: begin
                  if (ok && !cur.wlock[sector] && !bp_prot) begin
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                     // Full byte address kept; offset bits inside the page copied from the request
                     next_cur.ans.addr[fawp_pkg::PAGE_LSB-1:0] =
                        req.addr[fawp_pkg::PAGE_LSB-1:0];
                     next_cur.ans.data = req.old_data &
                                         req.new_data;
                  end
               end
               fawp_pkg::CMD_OTP_PROGRAM: begin
                  // One-time area has its own 6-bit address space
                  if (ok && req.addr < fawp_pkg::ADDR_W'(
                         fawp_pkg::OTP_BYTES)) begin
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                     next_cur.ans.data   = req.old_data &
                                           req.new_data;
                  end
               end
               fawp_pkg::CMD_PAGE_ERASE: begin
                  // No page-sized erase exists in this array
                  next_cur.ans.refuse = 1'b1;
               end
               fawp_pkg::CMD_SUBSECTOR_ERASE: begin
                  // Granted erase points at the 4 KB boundary
                  if (ok && !cur.wlock[sector] && !bp_prot) begin
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                     next_cur.ans.addr[fawp_pkg::SUBSECTOR_LSB-1:0] = '0;
                     next_cur.ans.data   = 8'hff;
                  end
               end
               fawp_pkg::CMD_SECTOR_ERASE: begin
                  // Granted erase points at the 64 KB boundary
                  if (ok && !cur.wlock[sector] && !bp_prot) begin
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                     next_cur.ans.addr[fawp_pkg::SECTOR_LSB-1:0] = '0;
                     next_cur.ans.data   = 8'hff;
                  end
               end
               fawp_pkg::CMD_BULK_ERASE: begin
                  // Whole array: any protected sector blocks it
                  if (ok && !any_lock && cur.bp == fawp_pkg::BP_NONE) begin
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                     next_cur.ans.addr   = '0;
                     next_cur.ans.data   = 8'hff;
                  end
               end
               fawp_pkg::CMD_WRITE_LOCK: begin
                  // A frozen sector keeps its lock until reset
                  if (ok && !cur.ldown[sector]) begin
                     next_cur.wlock[sector] = req.write_lock;
                     next_cur.ldown[sector] = req.lock_down;
                     next_cur.ans.grant     = 1'b1;
                     next_cur.ans.refuse    = 1'b0;
                  end
               end
               fawp_pkg::CMD_WRITE_STATUS: begin
                  // Pin low with protection on freezes the area bits
                  if (ok && !(wp_enable && !cur.wp_sync)) begin
                     next_cur.bp         = req.bp;
                     next_cur.top_bottom_select = req.top_bottom_select;
                     next_cur.ans.grant  = 1'b1;
                     next_cur.ans.refuse = 1'b0;
                  end
               end
               default: begin
                  next_cur.ans.refuse = 1'b1;
               end
            endcase
         end
         // Latch commands echo the stored byte untouched
         if (!modify)
            next_cur.ans.data = req.old_data;
      end
   end

   // State register; locks start protected, lock-downs open
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cur          <= '0;
         // Pin flops start at the pin's idle-high level
         cur.wp_meta  <= 1'b1;
         cur.wp_sync  <= 1'b1;
         cur.bp       <= fawp_pkg::BP_RESET;
         cur.top_bottom_select <= fawp_pkg::TOP_BOTTOM_RESET;
         cur.wlock    <= {fawp_pkg::SECTOR_COUNT{
                           fawp_pkg::WLOCK_RESET}};
         cur.ldown    <= {fawp_pkg::SECTOR_COUNT{
                           fawp_pkg::LDOWN_RESET}};
      end else begin
         cur <= next_cur;
      end
   end

   // Outputs come straight from the state register
   assign ans       = cur.ans;
   assign wel       = cur.wel;
   assign bp_status = cur.bp;
   assign top_bottom_status = cur.top_bottom_select;
   assign ready     = cur.pu_done;

endmodule : fawp_guard

// ---- verification/fawp_guard_checker.sv ----
// Purpose: Port assertions for the write protection guard
// Assumes: Single clock, async active-low reset
// Notes:   Bound to every fawp_guard instance
`timescale 1ns/1ns
module fawp_guard_checker (
   input wire logic                clk,             // Clock
   input wire logic                resetn,          // Reset, active low
   input wire logic                req_valid,       // Request strobe
   input wire fawp_pkg::fawp_req_t req,             // Request
   input wire logic                wp_enable,       // Pin mode
   input wire logic                write_protect_n, // Protect pin
   input wire fawp_pkg::fawp_ans_t ans,             // Answer
   input wire logic                wel,             // Enable latch
   input wire logic [3:0]          bp_status,       // Protect code
   input wire logic                top_bottom_status, // Top/bottom
   input wire logic                ready            // Power-up done
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // Latch set and clear are the only kinds that modify nothing
   logic mod;
   logic ers;
   assign mod = req_valid && req.kind != fawp_pkg::CMD_WRITE_ENABLE
                && req.kind != fawp_pkg::CMD_WRITE_DISABLE;
   assign ers = ans.kind inside {fawp_pkg::CMD_SUBSECTOR_ERASE,
                fawp_pkg::CMD_SECTOR_ERASE, fawp_pkg::CMD_BULK_ERASE};
   answer_once_a: assert property (
      req_valid |=> ans.grant != ans.refuse) else $error("no single answer");
   power_hold_a: assert property (
      req_valid && !ready && req.kind != fawp_pkg::CMD_WRITE_DISABLE
      |=> ans.refuse) else $error("granted too early");
   ready_keep_a: assert property (
      ready |=> ready) else $error("ready dropped");
   byte_count_a: assert property (
      mod && !req.byte_whole |=> ans.refuse) else $error("partial byte ran");
   latch_need_a: assert property (
      mod && !wel |=> ans.refuse) else $error("modify without latch");
   latch_clear_a: assert property (
      mod |=> !wel) else $error("latch not cleared");
   page_erase_a: assert property (
      req_valid && req.kind == fawp_pkg::CMD_PAGE_ERASE |=> ans.refuse)
      else $error("page erase ran");
   otp_range_a: assert property (
      req_valid && req.kind == fawp_pkg::CMD_OTP_PROGRAM && req.addr >= 64
      |=> ans.refuse) else $error("otp address out of range ran");
   program_data_a: assert property (
      req_valid && req.kind == fawp_pkg::CMD_PAGE_PROGRAM ##1 ans.grant |->
      ans.data == ($past(req.old_data) & $past(req.new_data)))
      else $error("program set a bit");
   erase_fill_a: assert property (
      ans.grant && ers |-> ans.data == 8'hff) else $error("erase not ones");
   sector_align_a: assert property (
      ans.grant && ans.kind == fawp_pkg::CMD_SECTOR_ERASE |->
      ans.addr[15:0] == 16'h0) else $error("sector address not aligned");
   subsector_align_a: assert property (
      ans.grant && ans.kind == fawp_pkg::CMD_SUBSECTOR_ERASE |->
      ans.addr[11:0] == 12'h0) else $error("subsector address not aligned");
   // Main scenarios reached
   cover property (ans.grant && ers);
   cover property (ans.refuse && ready);
   cover property (ans.grant && ans.kind == fawp_pkg::CMD_WRITE_LOCK);
endmodule : fawp_guard_checker
bind fawp_guard fawp_guard_checker u_chk (.clk, .resetn, .req_valid, .req,
   .wp_enable, .write_protect_n, .ans, .wel, .bp_status, .top_bottom_status,
   .ready);

// ---- verification/fawp_host_model.sv ----
// Purpose: Host model issuing flash commands to the guard
// Assumes: Bench raises send for one cycle per command
// Notes:   Can put the write enable ahead of the command itself
`timescale 1ns/1ns
module fawp_host_model (
   input  wire logic                clk,      // Clock
   input  wire logic                resetn,   // Reset, active low
   input  wire logic                send,     // Issue command
   input  wire logic                with_we,  // Write enable first
   input  wire fawp_pkg::fawp_req_t cmd,      // Command to issue
   output fawp_pkg::fawp_req_t      req,      // Request to guard
   output logic                     req_valid // Request strobe
);
   fawp_pkg::fawp_req_t hold;
   fawp_pkg::fawp_req_t we_req;
   logic                pend;
   // Write enable copy of the command, always a whole byte
   always_comb begin
      we_req            = cmd;
      we_req.kind       = fawp_pkg::CMD_WRITE_ENABLE;
      we_req.byte_whole = 1'b1;
   end
   // Idle fields toggle so a stale request is never mistaken for live
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         req_valid <= 1'b0;
         pend      <= 1'b0;
         req       <= '0;
      end else if (send) begin
         req_valid <= 1'b1;
         req       <= with_we ? we_req : cmd;
         hold      <= cmd;
         pend      <= with_we;
      end else if (pend) begin
         req_valid <= 1'b1;
         req       <= hold;
         pend      <= 1'b0;
      end else begin
         req_valid <= 1'b0;
         req       <= fawp_pkg::fawp_req_t'(~req);
      end
   end
endmodule : fawp_host_model

// ---- verification/tb_flash_array_write_protection.sv ----
// Purpose: Self-checking bench for the write protection guard
// Assumes: Host model drives requests, bench notes expected answers
// Notes:   Power-up hold-off is run in full twice
`timescale 1ns/1ns
module tb_flash_array_write_protection;
   logic                clk, resetn, send, with_we;
   logic                wp_enable, write_protect_n, req_valid;
   logic                wel, top_bottom_status, ready;
   logic [3:0]          bp_status;
   fawp_pkg::fawp_req_t cmd, req;
   fawp_pkg::fawp_ans_t ans;
   logic [9:0]          exp_q[$];
   logic [9:0]          e;
   logic [7:0]          rnd = 8'h3c;
   int                  error_cnt = 0;
   int                  total_checks = 0;
   int                  ss[6] = '{0, 1, 255, 256, 510, 511};
   fawp_host_model HOST (.clk(clk), .resetn(resetn), .send(send),
      .with_we(with_we), .cmd(cmd), .req(req), .req_valid(req_valid));
   fawp_guard DUT (.clk(clk), .resetn(resetn), .req_valid(req_valid),
      .req(req), .wp_enable(wp_enable), .write_protect_n(write_protect_n),
      .ans(ans), .wel(wel), .bp_status(bp_status),
      .top_bottom_status(top_bottom_status), .ready(ready));
   // Clock
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic check(string what, logic [7:0] x, logic [7:0] got);
      total_checks++;
      if (got !== x) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, x, got);
      end
   endtask : check
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : final_report
   function automatic logic [7:0] lfsr(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr
   function automatic logic bp_prot(logic [3:0] c, logic t, int s);
      if (c == 4'h0) return 1'b0;
      if (c > 4'h9) return 1'b1;
      return t ? s < (1 << (c - 1)) : s >= 512 - (1 << (c - 1));
   endfunction : bp_prot
   // Issue one command and note its answer, and the write enable's first
   task automatic issue(fawp_pkg::fawp_cmd_t k, logic [24:0] a, logic we,
                        logic g);
      logic pr;
      pr = k == fawp_pkg::CMD_PAGE_PROGRAM || k == fawp_pkg::CMD_OTP_PROGRAM;
      rnd = lfsr(rnd);
      cmd.new_data = rnd;
      rnd = lfsr(rnd);
      cmd.old_data = rnd;
      cmd.kind = k;
      cmd.addr = a;
      if (we) exp_q.push_back(10'h100);
      exp_q.push_back({g && (pr || k inside {fawp_pkg::CMD_SECTOR_ERASE,
         fawp_pkg::CMD_SUBSECTOR_ERASE}), g,
         pr ? cmd.old_data & cmd.new_data : 8'hff});
      send = 1'b1;
      with_we = we;
      @(posedge clk);
      #1 send = 1'b0;
      repeat (we ? 3 : 2) @(posedge clk);
      #1;
   endtask : issue
   task automatic wait_ready();
      for (int i = 0; i < 4000 && ready !== 1'b1; i++) @(posedge clk);
      #1;
      check("ready", 8'h01, {7'h0, ready});
   endtask : wait_ready
   // Oldest note against each answer pulse
   always @(posedge clk) begin
      #2;
      if (ans.grant === 1'b1 || ans.refuse === 1'b1) begin
         e = exp_q.size() > 0 ? exp_q.pop_front() : 10'bx;
         check("grant", {7'h0, e[8]}, {7'h0, ans.grant});
         if (e[9] === 1'b1) check("data", e[7:0], ans.data);
      end
   end
   // Hang guard, reckoned well beyond two hold-offs plus traffic
   initial begin
      #(100 * 20000);
      error_cnt++;
      final_report();
   end
   initial begin
      {send, with_we, wp_enable, resetn} = 4'h0;
      write_protect_n = 1'b1;
      cmd = '0;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      cmd.byte_whole = 1'b1;
      issue(fawp_pkg::CMD_WRITE_ENABLE, 0, 0, 0);
      wait_ready();
      issue(fawp_pkg::CMD_SECTOR_ERASE, 0, 1, 0);
      issue(fawp_pkg::CMD_WRITE_LOCK, 0, 1, 1);
      issue(fawp_pkg::CMD_SECTOR_ERASE, 25'h0abcd, 1, 1);
      issue(fawp_pkg::CMD_SUBSECTOR_ERASE, 25'h1000, 1, 1);
      issue(fawp_pkg::CMD_PAGE_PROGRAM, 25'h100, 0, 0);
      cmd.byte_whole = 1'b0;
      issue(fawp_pkg::CMD_PAGE_PROGRAM, 25'h100, 1, 0);
      cmd.byte_whole = 1'b1;
      issue(fawp_pkg::CMD_PAGE_ERASE, 25'h100, 1, 0);
      issue(fawp_pkg::CMD_PAGE_PROGRAM, 25'h1ff, 1, 1);
      issue(fawp_pkg::CMD_OTP_PROGRAM, 25'd64, 1, 0);
      issue(fawp_pkg::CMD_OTP_PROGRAM, 25'd63, 1, 1);
      issue(fawp_pkg::CMD_BULK_ERASE, 0, 1, 0);
      issue(fawp_pkg::CMD_WRITE_DISABLE, 0, 1, 1);
      issue(fawp_pkg::CMD_PAGE_PROGRAM, 25'h200, 0, 0);
      $display("test basic gating done");
      cmd.lock_down = 1'b1;
      issue(fawp_pkg::CMD_WRITE_LOCK, 25'h10000, 1, 1);
      {cmd.lock_down, cmd.write_lock} = 2'h1;
      issue(fawp_pkg::CMD_WRITE_LOCK, 25'h10000, 1, 0);
      cmd.write_lock = 1'b0;
      foreach (ss[i])
         issue(fawp_pkg::CMD_WRITE_LOCK, {ss[i][8:0], 16'h0}, 1,
               ss[i] != 1);
      $display("test sector locks done");
      for (int t = 0; t < 2; t++) begin
         for (int c = 0; c < 16; c++) begin
            cmd.bp = c[3:0];
            cmd.top_bottom_select = t[0];
            issue(fawp_pkg::CMD_WRITE_STATUS, 0, 1, 1);
            check("bp_status", {4'h0, c[3:0]}, {4'h0, bp_status});
            check("top_bottom", {7'h0, t[0]},
                  {7'h0, top_bottom_status});
            foreach (ss[i])
               issue(fawp_pkg::CMD_PAGE_PROGRAM, {ss[i][8:0], 16'h0}, 1,
                     !bp_prot(c[3:0], t[0], ss[i]));
         end
      end
      $display("test block protect done");
      {wp_enable, write_protect_n} = 2'h2;
      repeat (4) @(posedge clk);
      #1 cmd.bp = 4'h5;
      issue(fawp_pkg::CMD_WRITE_STATUS, 0, 1, 0);
      check("bp_status", 8'h0f, {4'h0, bp_status});
      resetn = 1'b0;
      repeat (8) @(posedge clk);
      #1 resetn = 1'b1;
      check("bp_status", 8'h00, {4'h0, bp_status});
      check("ready", 8'h00, {7'h0, ready});
      wait_ready();
      issue(fawp_pkg::CMD_SECTOR_ERASE, 0, 1, 0);
      issue(fawp_pkg::CMD_WRITE_LOCK, 25'h10000, 1, 1);
      check("left over", 8'h00, 8'(exp_q.size()));
      $display("test pin and reset done");
      final_report();
   end
endmodule : tb_flash_array_write_protection
